// ===== src/counter_array_pkg.sv
// Constants and state type for the two-block counter array pulse generator.
// Assumes an 8-bit special-function register port on the processor clock.
// Behaviour
// R01 - Programmable-period mode: low byte equal to period clears counter and reloads holding registers.
// R02 - One period register per block serves all three compare modules.
// R03 - Software keeps every module of a programmable block in that mode or unused.
// R04 - Each module takes its own duty from its compare high register.
// R05 - Software keeps the period above every module's duty value.
// R06 - 16-bit mode: output high while counter >= compare, low on counter overflow.
// R07 - Software sets all three modules of a block to 10-bit mode together.
// R08 - 10-bit mode: 10-bit counter and compare, high at >=, low on 10-bit overflow.
// R09 - 10-bit mode ignores upper six bits of counter high and compare high.
// R10 - Software writes compare low before compare high.
// R11 - Compare low write clears comparator enable; compare high write sets it.
// R12 - Compare zero gives full duty; clear comparator enable holds output low.
// R13 - Global start bit in block 0 control runs both counters, overriding run bits.
// R14 - Control bit 6 runs or stops its block's counter; only software changes it.
// R15 - Control bit 5 enables the interrupt from that block's overflow flag.
// R16 - Control bit 4 halts the counter while the processor idles.
// R17 - Control bit 2 selects 10-bit rather than 16-bit wide pulse mode.
// R18 - Clock select: 00 prescaler, 01 timer 0 overflow, 10 external pin.
// R19 - Status layout: overflow flags at 7 and 3, module flags around them.
// R20 - Overflow flag set on rollover or by software; cleared only by software.
// R21 - All eight event flags are ORed into one interrupt request; the code ORs each flag only while its enable bit is set.
// R22 - Mode field: 01 fixed 8-bit, 10 programmable 8-bit, 11 wide fixed.
// R23 - 8-bit modes: high when low byte >= compare low; restart copies high to low.
// R24 - Programmable mode drives the output low when the period match clears the counter.
package counter_array_pkg;
  localparam int NUM_BLOCKS = 2;
  localparam int MODS_PER_BLOCK = 3;
  localparam int NUM_MODS = 6;

  localparam logic [7:0] ADDR_STATUS = 8'hA5;
  localparam logic [1:0][7:0] ADDR_CNT_LO = {8'hBA, 8'hA2};
  localparam logic [1:0][7:0] ADDR_CNT_HI = {8'hBB, 8'hA3};
  localparam logic [1:0][7:0] ADDR_CTRL = {8'hBC, 8'hA4};
  localparam logic [1:0][7:0] ADDR_PERIOD = {8'hC7, 8'hB4};
  localparam logic [5:0][7:0] ADDR_MODE = {8'hBF, 8'hBE, 8'hBD, 8'hAB, 8'hAA, 8'hA9};
  localparam logic [5:0][7:0] ADDR_CMP_LO = {8'hC5, 8'hC3, 8'hC1, 8'hB2, 8'hAF, 8'hAC};
  localparam logic [5:0][7:0] ADDR_CMP_HI = {8'hC6, 8'hC4, 8'hC2, 8'hB3, 8'hB1, 8'hAD};

  localparam int CTRL_START_ALL = 7;
  localparam int CTRL_RUN = 6;
  localparam int CTRL_OVF_IRQ = 5;
  localparam int CTRL_IDLE_HALT = 4;
  localparam int CTRL_TEN_BIT = 2;
  localparam logic [1:0][7:0] CTRL_WMASK = {8'h77, 8'hF7};

  localparam int MODE_IRQ_EN = 7;
  localparam int MODE_CMP_EN = 6;
  localparam int MODE_MATCH = 3;
  localparam logic [1:0] PWM_OFF = 2'h0;
  localparam logic [1:0] PWM_FIX8 = 2'h1;
  localparam logic [1:0] PWM_PROG8 = 2'h2;
  localparam logic [1:0] PWM_WIDE = 2'h3;

  localparam logic [1:0] CLK_PRESCALE = 2'h0;
  localparam logic [1:0] CLK_TIMER0 = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h2;

  localparam logic [7:0] STA_OVF_MASK = 8'h88;
  localparam logic [7:0] STA_FLAG_MASK = 8'h77;
  localparam logic [1:0][2:0] STA_OVF_BIT = {3'h7, 3'h3};
  localparam logic [5:0][2:0] STA_FLAG_BIT = {3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [5:0] TEN_UPPER_ZERO = 6'h00;

  typedef struct packed {
    logic [1:0][15:0] cnt;
    logic [1:0][7:0] ctrl;
    logic [7:0] sta;
    logic [5:0][7:0] mode;
    logic [5:0][7:0] cmp_lo;
    logic [5:0][7:0] cmp_hi;
    logic [1:0][7:0] period;
    logic [1:0][7:0] period_hold;
    logic [5:0] pin;
    logic [7:0] rdata;
    logic irq;
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic [1:0] ext_prev;
  } state_t;
endpackage : counter_array_pkg

// ===== src/counter_array_pwm_control.sv
// Two counter blocks with three pulse-width compare modules each.
// Assumes tick inputs on clk and external clock pins from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module counter_array_pwm_control
  import counter_array_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] prescale_tick,
  input wire logic timer0_ovf,
  input wire logic [1:0] ext_clk_pin,
  input wire logic cpu_idle,
  output logic [5:0] module_output_pin,
  output logic irq
);
  state_t q;
  state_t d;
  logic [1:0] tick;
  logic [1:0] prog;
  logic [1:0] period_hit;

  // Counter clock choice, run control and programmable-period detection per block.
  always_comb begin
    for (int b = 0; b < NUM_BLOCKS; b++) begin
      tick[b] = 1'b0;
      if (q.ctrl[b][1:0] == CLK_PRESCALE) begin // [R18]
        tick[b] = prescale_tick[b];
      end else if (q.ctrl[b][1:0] == CLK_TIMER0) begin // [R18]
        tick[b] = timer0_ovf;
      end else if (q.ctrl[b][1:0] == CLK_EXT) begin // [R18]
        tick[b] = q.ext_s2[b] & ~q.ext_prev[b];
      end
      tick[b] = tick[b] & (q.ctrl[0][CTRL_START_ALL] | q.ctrl[b][CTRL_RUN]) // [R13] [R14]
        & ~(cpu_idle & q.ctrl[b][CTRL_IDLE_HALT]); // [R16]
      prog[b] = 1'b0;
      for (int m = 0; m < MODS_PER_BLOCK; m++) begin
        if (q.mode[b * MODS_PER_BLOCK + m][1:0] == PWM_PROG8) begin
          prog[b] = 1'b1;
        end
      end
      period_hit[b] = (q.cnt[b][7:0] == q.period_hold[b]); // [R01] [R02]
    end
  end

  always_comb begin
    logic [1:0] ovf;
    logic [7:0] set_mask;
    logic [7:0] irq_en;
    int b;
    ovf = 2'h0;
    set_mask = BYTE_RESET;
    irq_en = BYTE_RESET;
    b = 0;
    d = q;
    d.ext_s1 = ext_clk_pin;
    d.ext_s2 = q.ext_s1;
    d.ext_prev = q.ext_s2;

    // Counters.
    for (int k = 0; k < NUM_BLOCKS; k++) begin
      if (tick[k]) begin
        if (prog[k]) begin
          if (period_hit[k]) begin
            d.cnt[k] = COUNT_RESET; // [R01]
            d.period_hold[k] = q.period[k]; // [R01] [R02]
          end else begin
            d.cnt[k] = q.cnt[k] + 16'h0001;
          end
        end else if (q.ctrl[k][CTRL_TEN_BIT]) begin
          d.cnt[k] = {TEN_UPPER_ZERO, q.cnt[k][9:0] + 10'h001}; // [R08] [R09] [R17]
          ovf[k] = &q.cnt[k][9:0]; // [R08]
        end else begin
          d.cnt[k] = q.cnt[k] + 16'h0001;
          ovf[k] = &q.cnt[k]; // [R06]
        end
      end
      if (ovf[k]) begin
        set_mask[STA_OVF_BIT[k]] = 1'b1; // [R20]
      end
    end

    // Compare modules.
    for (int i = 0; i < NUM_MODS; i++) begin
      b = i / MODS_PER_BLOCK;
      if (tick[b]) begin
        case (q.mode[i][1:0])
          PWM_FIX8: begin
            if (&q.cnt[b][7:0]) begin
              d.cmp_lo[i] = q.cmp_hi[i]; // [R23]
              d.pin[i] = 1'b0;
            end else begin
              d.pin[i] = (d.cnt[b][7:0] >= q.cmp_lo[i]); // [R23] [R22]
            end
          end
          PWM_PROG8: begin
            if (period_hit[b]) begin
              d.cmp_lo[i] = q.cmp_hi[i]; // [R04] [R23]
              d.pin[i] = 1'b0; // [R24]
            end else begin
              d.pin[i] = (d.cnt[b][7:0] >= q.cmp_lo[i]); // [R04] [R22]
            end
          end
          PWM_WIDE: begin
            if (ovf[b]) begin
              d.pin[i] = 1'b0; // [R06] [R08]
            end else if (q.ctrl[b][CTRL_TEN_BIT]) begin
              d.pin[i] = (d.cnt[b][9:0] >= {q.cmp_hi[i][1:0], q.cmp_lo[i]}); // [R08] [R09]
            end else begin
              d.pin[i] = (d.cnt[b] >= {q.cmp_hi[i], q.cmp_lo[i]}); // [R06] [R12]
            end
          end
          default: begin
            d.pin[i] = 1'b0; // [R22]
          end
        endcase
        if (q.mode[i][MODE_MATCH] && q.mode[i][MODE_CMP_EN]
            && d.cnt[b] == {q.cmp_hi[i], q.cmp_lo[i]}) begin
          set_mask[STA_FLAG_BIT[i]] = 1'b1; // [R19]
        end
      end
      if (!q.mode[i][MODE_CMP_EN] || q.mode[i][1:0] == PWM_OFF) begin
        d.pin[i] = 1'b0; // [R12]
      end
      irq_en[STA_FLAG_BIT[i]] = q.mode[i][MODE_IRQ_EN];
    end
    for (int k = 0; k < NUM_BLOCKS; k++) begin
      irq_en[STA_OVF_BIT[k]] = q.ctrl[k][CTRL_OVF_IRQ]; // [R15]
    end
    d.irq = |(q.sta & irq_en); // [R21]

    // Register writes.
    if (sfr_wr) begin
      if (sfr_addr == ADDR_STATUS) begin
        d.sta = (sfr_wdata & STA_OVF_MASK) | (q.sta & sfr_wdata & STA_FLAG_MASK); // [R19] [R20]
      end
      for (int k = 0; k < NUM_BLOCKS; k++) begin
        if (sfr_addr == ADDR_CTRL[k]) begin
          d.ctrl[k] = sfr_wdata & CTRL_WMASK[k]; // [R14]
        end else if (sfr_addr == ADDR_CNT_LO[k]) begin
          d.cnt[k][7:0] = sfr_wdata;
        end else if (sfr_addr == ADDR_CNT_HI[k]) begin
          d.cnt[k][15:8] = sfr_wdata;
        end else if (sfr_addr == ADDR_PERIOD[k]) begin
          d.period[k] = sfr_wdata; // [R02]
        end
      end
      for (int i = 0; i < NUM_MODS; i++) begin
        if (sfr_addr == ADDR_MODE[i]) begin
          d.mode[i] = sfr_wdata;
        end else if (sfr_addr == ADDR_CMP_LO[i]) begin
          d.cmp_lo[i] = sfr_wdata;
          d.mode[i][MODE_CMP_EN] = 1'b0; // [R11]
        end else if (sfr_addr == ADDR_CMP_HI[i]) begin
          d.cmp_hi[i] = sfr_wdata;
          d.mode[i][MODE_CMP_EN] = 1'b1; // [R11]
        end
      end
    end
    d.sta = d.sta | set_mask; // [R20]

    // Register reads.
    if (sfr_rd) begin
      d.rdata = BYTE_RESET;
      if (sfr_addr == ADDR_STATUS) begin
        d.rdata = q.sta;
      end
      for (int k = 0; k < NUM_BLOCKS; k++) begin
        if (sfr_addr == ADDR_CTRL[k]) begin
          d.rdata = q.ctrl[k];
        end else if (sfr_addr == ADDR_CNT_LO[k]) begin
          d.rdata = q.cnt[k][7:0];
        end else if (sfr_addr == ADDR_CNT_HI[k]) begin
          d.rdata = q.cnt[k][15:8];
        end else if (sfr_addr == ADDR_PERIOD[k]) begin
          d.rdata = q.period[k];
        end
      end
      for (int i = 0; i < NUM_MODS; i++) begin
        if (sfr_addr == ADDR_MODE[i]) begin
          d.rdata = q.mode[i];
        end else if (sfr_addr == ADDR_CMP_LO[i]) begin
          d.rdata = q.cmp_lo[i];
        end else if (sfr_addr == ADDR_CMP_HI[i]) begin
          d.rdata = q.cmp_hi[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign module_output_pin = q.pin;
  assign irq = q.irq;
  assign sfr_rdata = q.rdata;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_cmp_lo_clears: assert property ( // [R11]
    sfr_wr && sfr_addr == ADDR_CMP_LO[0] |=> !q.mode[0][MODE_CMP_EN])
    else $error("Compare low write left comparator enabled.");
  chk_cmp_hi_sets: assert property ( // [R11]
    sfr_wr && sfr_addr == ADDR_CMP_HI[0] |=> q.mode[0][MODE_CMP_EN])
    else $error("Compare high write did not enable comparator.");
  chk_disabled_low: assert property ( // [R12]
    !q.mode[0][MODE_CMP_EN] |=> !module_output_pin[0])
    else $error("Disabled module output went high.");
  chk_period_clear: assert property ( // [R01]
    tick[0] && prog[0] && period_hit[0] && !sfr_wr
    |=> q.cnt[0] == COUNT_RESET && q.period_hold[0] == $past(q.period[0]))
    else $error("Period match did not clear counter and reload period.");
  chk_prog_restart_low: assert property ( // [R24]
    tick[0] && period_hit[0] && q.mode[0][1:0] == PWM_PROG8 |=> !module_output_pin[0])
    else $error("Output not low at period restart.");
  chk_counter_stopped: assert property ( // [R14]
    !q.ctrl[0][CTRL_RUN] && !q.ctrl[0][CTRL_START_ALL] && !sfr_wr |=> $stable(q.cnt[0]))
    else $error("Stopped counter moved.");
  chk_idle_halt: assert property ( // [R16]
    cpu_idle && q.ctrl[0][CTRL_IDLE_HALT] && !sfr_wr |=> $stable(q.cnt[0]))
    else $error("Counter ran during idle halt.");
  chk_ovf_sticky: assert property ( // [R20]
    q.sta[STA_OVF_BIT[0]] && !(sfr_wr && sfr_addr == ADDR_STATUS) |=> q.sta[STA_OVF_BIT[0]])
    else $error("Overflow flag cleared without a write.");
  chk_ovf_irq: assert property ( // [R15] [R21]
    q.sta[STA_OVF_BIT[0]] && q.ctrl[0][CTRL_OVF_IRQ] |=> irq)
    else $error("Enabled overflow flag gave no interrupt.");
  chk_ten_wrap: assert property ( // [R08]
    tick[0] && !prog[0] && q.ctrl[0][CTRL_TEN_BIT] && !sfr_wr
    |=> q.cnt[0][15:10] == TEN_UPPER_ZERO)
    else $error("10-bit counter left upper bits set.");

  chk_cmp_lo_clears1: assert property ( // [R11]
    sfr_wr && sfr_addr == ADDR_CMP_LO[3] |=> !q.mode[3][MODE_CMP_EN])
    else $error("Block 1 compare low write left comparator enabled.");

  chk_cmp_hi_sets1: assert property ( // [R11]
    sfr_wr && sfr_addr == ADDR_CMP_HI[3] |=> q.mode[3][MODE_CMP_EN])
    else $error("Block 1 compare high write did not enable comparator.");

  chk_disabled_low3: assert property ( // [R12]
    !q.mode[3][MODE_CMP_EN] |=> !module_output_pin[3])
    else $error("Disabled block 1 output went high.");

  chk_mode_off_low: assert property ( // [R22]
    q.mode[0][1:0] == PWM_OFF |=> !module_output_pin[0])
    else $error("Output high with pulse mode off.");

  chk_period_clear1: assert property ( // [R01]
    tick[1] && prog[1] && period_hit[1] && !sfr_wr
    |=> q.cnt[1] == COUNT_RESET && q.period_hold[1] == $past(q.period[1]))
    else $error("Block 1 period match did not clear counter.");

  chk_prog_restart_low3: assert property ( // [R24]
    tick[1] && period_hit[1] && q.mode[3][1:0] == PWM_PROG8 |=> !module_output_pin[3])
    else $error("Block 1 output not low at period restart.");

  chk_counter_stopped1: assert property ( // [R14]
    !q.ctrl[1][CTRL_RUN] && !q.ctrl[0][CTRL_START_ALL] && !sfr_wr |=> $stable(q.cnt[1]))
    else $error("Stopped block 1 counter moved.");

  chk_idle_halt1: assert property ( // [R16]
    cpu_idle && q.ctrl[1][CTRL_IDLE_HALT] && !sfr_wr |=> $stable(q.cnt[1]))
    else $error("Block 1 counter ran during idle halt.");

  chk_ovf_sticky1: assert property ( // [R20]
    q.sta[STA_OVF_BIT[1]] && !(sfr_wr && sfr_addr == ADDR_STATUS) |=> q.sta[STA_OVF_BIT[1]])
    else $error("Block 1 overflow flag cleared without a write.");

  chk_ovf_irq1: assert property ( // [R15] [R21]
    q.sta[STA_OVF_BIT[1]] && q.ctrl[1][CTRL_OVF_IRQ] |=> irq)
    else $error("Enabled block 1 overflow gave no interrupt.");

  chk_ten_wrap1: assert property ( // [R08]
    tick[1] && !prog[1] && q.ctrl[1][CTRL_TEN_BIT] && !sfr_wr
    |=> q.cnt[1][15:10] == TEN_UPPER_ZERO)
    else $error("Block 1 10-bit counter left upper bits set.");

  chk_ovf_sets: assert property ( // [R20]
    tick[0] && !prog[0] && !q.ctrl[0][CTRL_TEN_BIT] && &q.cnt[0] |=> q.sta[STA_OVF_BIT[0]])
    else $error("16-bit rollover did not set overflow flag.");

  chk_ten_ovf_sets: assert property ( // [R08] [R20]
    tick[0] && !prog[0] && q.ctrl[0][CTRL_TEN_BIT] && &q.cnt[0][9:0]
    |=> q.sta[STA_OVF_BIT[0]])
    else $error("10-bit rollover did not set overflow flag.");

  chk_wide_ovf_low: assert property ( // [R06]
    tick[0] && !prog[0] && q.mode[0][1:0] == PWM_WIDE && !q.ctrl[0][CTRL_TEN_BIT]
    && &q.cnt[0] |=> !module_output_pin[0])
    else $error("16-bit output not low after overflow.");

  chk_ten_ovf_low: assert property ( // [R08]
    tick[0] && !prog[0] && q.mode[0][1:0] == PWM_WIDE && q.ctrl[0][CTRL_TEN_BIT]
    && &q.cnt[0][9:0] |=> !module_output_pin[0])
    else $error("10-bit output not low after overflow.");

  chk_fix8_restart: assert property ( // [R23]
    tick[0] && q.mode[0][1:0] == PWM_FIX8 && &q.cnt[0][7:0] && !sfr_wr
    |=> !module_output_pin[0] && q.cmp_lo[0] == $past(q.cmp_hi[0]))
    else $error("Fixed 8-bit restart did not reload duty.");

  chk_prog_reload: assert property ( // [R04] [R23]
    tick[0] && period_hit[0] && q.mode[0][1:0] == PWM_PROG8 && !sfr_wr
    |=> q.cmp_lo[0] == $past(q.cmp_hi[0]))
    else $error("Programmable restart did not reload duty.");

  chk_start_all_runs: assert property ( // [R13]
    q.ctrl[0][CTRL_START_ALL] && q.ctrl[1][1:0] == CLK_PRESCALE && prescale_tick[1]
    && !cpu_idle && !prog[1] && !sfr_wr |=> q.cnt[1] != $past(q.cnt[1]))
    else $error("Global start did not run block 1.");

  chk_irq_off: assert property ( // [R21]
    q.sta == BYTE_RESET |=> !irq)
    else $error("Interrupt raised with no flag set.");

  chk_flag_irq: assert property ( // [R21]
    q.sta[STA_FLAG_BIT[0]] && q.mode[0][MODE_IRQ_EN] |=> irq)
    else $error("Enabled module flag gave no interrupt.");

  chk_flag_sticky: assert property ( // [R19]
    q.sta[STA_FLAG_BIT[0]] && !(sfr_wr && sfr_addr == ADDR_STATUS) |=> q.sta[STA_FLAG_BIT[0]])
    else $error("Module flag cleared without a write.");

  chk_ctrl1_mask: assert property ( // [R13]
    sfr_wr && sfr_addr == ADDR_CTRL[1] |=> !q.ctrl[1][CTRL_START_ALL])
    else $error("Block 1 control took a global start bit.");

  chk_ovf_soft_set: assert property ( // [R20]
    sfr_wr && sfr_addr == ADDR_STATUS && sfr_wdata[STA_OVF_BIT[1]] |=> q.sta[STA_OVF_BIT[1]])
    else $error("Software could not set overflow flag.");

  chk_pin_hold: assert property ( // [R22]
    !tick[0] && q.mode[0][MODE_CMP_EN] && q.mode[0][1:0] != PWM_OFF
    |=> $stable(module_output_pin[0]))
    else $error("Output changed without a counter tick.");

  chk_period_write: assert property ( // [R02]
    sfr_wr && sfr_addr == ADDR_PERIOD[0] |=> q.period[0] == $past(sfr_wdata))
    else $error("Period register write lost.");
endmodule : counter_array_pwm_control
`default_nettype wire

// ===== test/load_model.sv
// External loads on the six pulse output pins.
// Assumes pins are sampled on clk; records which pins have gone high.
`timescale 1ns/10ps
`default_nettype none
module load_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] pins,
  output logic [5:0] seen_high
);
  // A load only observes the pins, it never drives them back.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_high <= 6'h00;
    end else begin
      seen_high <= seen_high | pins;
    end
  end
endmodule : load_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the counter array pulse generator.
// Assumes register access by one-cycle read and write strobes on clk.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import counter_array_pkg::*;
  logic clk, reset_n, sfr_wr, sfr_rd, timer0_ovf, cpu_idle, irq;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [1:0] prescale_tick, ext_clk_pin;
  logic [5:0] module_output_pin, seen_high;
  int err_total, n_tests, cycles;

  counter_array_pwm_control dut_u (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .prescale_tick(prescale_tick), .timer0_ovf(timer0_ovf), .ext_clk_pin(ext_clk_pin),
    .cpu_idle(cpu_idle), .module_output_pin(module_output_pin), .irq(irq));
  load_model load_u (.clk(clk), .reset_n(reset_n), .pins(module_output_pin),
    .seen_high(seen_high));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      conclude();
    end
  end

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask : chk

  task pchk(input logic b);
    chk("pin0", {7'h00, b}, {7'h00, module_output_pin[0]});
  endtask : pchk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= v;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1;
    v = sfr_rdata;
  endtask : rd

  task pulse(input logic [1:0] p, input logic t);
    @(posedge clk);
    prescale_tick <= p;
    timer0_ovf <= t;
    @(posedge clk);
    prescale_tick <= 2'h0;
    timer0_ovf <= 1'b0;
    #1;
  endtask : pulse

  initial begin
    {sfr_wr, sfr_rd, timer0_ovf, cpu_idle} = 4'h0;
    {sfr_addr, sfr_wdata, prescale_tick, ext_clk_pin} = 20'h00000;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_CTRL[0], d); chk("ctrl0", 8'h00, d);
    rd(ADDR_STATUS, d); chk("status", 8'h00, d);
    rd(ADDR_CTRL[1], d); chk("ctrl1", 8'h00, d);
    $display("test reset done");
    wr(ADDR_MODE[0], 8'h03); wr(ADDR_CMP_LO[0], 8'h03); wr(ADDR_CMP_HI[0], 8'h00);
    rd(ADDR_MODE[0], d); chk("mode0", 8'h43, d);
    wr(ADDR_CTRL[0], 8'h60); wr(ADDR_CNT_LO[0], 8'h01); wr(ADDR_CNT_HI[0], 8'h00);
    pulse(2'h1, 1'b0); pchk(1'b0);
    pulse(2'h1, 1'b0); pchk(1'b1);
    wr(ADDR_CNT_LO[0], 8'hFF); wr(ADDR_CNT_HI[0], 8'hFF);
    pulse(2'h1, 1'b0); pchk(1'b0);
    rd(ADDR_STATUS, d); chk("status", 8'h08, d);
    chk("irq", 8'h01, {7'h00, irq});
    wr(ADDR_STATUS, 8'h00); rd(ADDR_STATUS, d); chk("status", 8'h00, d);
    chk("irq", 8'h00, {7'h00, irq});
    wr(ADDR_STATUS, 8'h08); rd(ADDR_STATUS, d); chk("status", 8'h08, d);
    wr(ADDR_STATUS, 8'h00);
    $display("test wide done");
    wr(ADDR_CMP_LO[0], 8'h00); rd(ADDR_MODE[0], d); chk("mode0", 8'h03, d);
    pchk(1'b0);
    wr(ADDR_CMP_HI[0], 8'h00); pulse(2'h1, 1'b0); pchk(1'b1);
    chk("load0", 8'h01, {7'h00, seen_high[0]});
    wr(ADDR_CMP_LO[0], 8'h00); repeat (2) @(posedge clk); #1; pchk(1'b0);
    $display("test duty done");
    wr(ADDR_MODE[1], 8'h03); wr(ADDR_MODE[2], 8'h03);
    wr(ADDR_CTRL[0], 8'h44); wr(ADDR_CMP_LO[0], 8'h00); wr(ADDR_CMP_HI[0], 8'hF1);
    wr(ADDR_CNT_LO[0], 8'hFE); wr(ADDR_CNT_HI[0], 8'hFC);
    pulse(2'h1, 1'b0); pchk(1'b0);
    pulse(2'h1, 1'b0); pchk(1'b1);
    wr(ADDR_CNT_LO[0], 8'hFF); wr(ADDR_CNT_HI[0], 8'h03);
    pulse(2'h1, 1'b0); pchk(1'b0);
    $display("test ten bit done");
    wr(ADDR_CTRL[0], 8'h40); wr(ADDR_MODE[0], 8'h01);
    wr(ADDR_CMP_LO[0], 8'h02); wr(ADDR_CMP_HI[0], 8'h10);
    wr(ADDR_CNT_HI[0], 8'h00); wr(ADDR_CNT_LO[0], 8'h00);
    pulse(2'h1, 1'b0); pchk(1'b0);
    pulse(2'h1, 1'b0); pchk(1'b1);
    wr(ADDR_CNT_LO[0], 8'hFF); pulse(2'h1, 1'b0); pchk(1'b0);
    wr(ADDR_CNT_LO[0], 8'h05); pulse(2'h1, 1'b0); pchk(1'b0);
    wr(ADDR_CNT_LO[0], 8'h0F); pulse(2'h1, 1'b0); pchk(1'b1);
    $display("test fixed eight done");
    wr(ADDR_MODE[1], 8'h00); wr(ADDR_MODE[2], 8'h00);
    wr(ADDR_MODE[0], 8'h02); wr(ADDR_PERIOD[0], 8'h05);
    wr(ADDR_CMP_LO[0], 8'h02); wr(ADDR_CMP_HI[0], 8'h02);
    wr(ADDR_CNT_LO[0], 8'h00); wr(ADDR_CNT_HI[0], 8'h00);
    repeat (16) pulse(2'h1, 1'b0);
    pchk(1'b1);
    rd(ADDR_CNT_LO[0], d); chk("cnt0_lo", 8'h03, d);
    rd(ADDR_CNT_HI[0], d); chk("cnt0_hi", 8'h00, d);
    $display("test programmable done");
    wr(ADDR_MODE[0], 8'h00); repeat (2) @(posedge clk); #1; pchk(1'b0);
    wr(ADDR_CNT_LO[0], 8'h20); wr(ADDR_CTRL[0], 8'h50);
    cpu_idle <= 1'b1;
    pulse(2'h1, 1'b0); rd(ADDR_CNT_LO[0], d); chk("cnt0_lo", 8'h20, d);
    wr(ADDR_CTRL[0], 8'h40);
    pulse(2'h1, 1'b0); rd(ADDR_CNT_LO[0], d); chk("cnt0_lo", 8'h21, d);
    cpu_idle <= 1'b0;
    wr(ADDR_CTRL[0], 8'h41);
    pulse(2'h1, 1'b0); rd(ADDR_CNT_LO[0], d); chk("cnt0_lo", 8'h21, d);
    pulse(2'h0, 1'b1); rd(ADDR_CNT_LO[0], d); chk("cnt0_lo", 8'h22, d);
    wr(ADDR_CTRL[0], 8'h42);
    ext_clk_pin <= 2'h1;
    repeat (4) @(posedge clk);
    ext_clk_pin <= 2'h0;
    repeat (4) @(posedge clk);
    rd(ADDR_CNT_LO[0], d); chk("cnt0_lo", 8'h23, d);
    $display("test clocking done");
    wr(ADDR_CTRL[0], 8'h80); wr(ADDR_CNT_LO[1], 8'h00);
    pulse(2'h2, 1'b0); rd(ADDR_CNT_LO[1], d); chk("cnt1_lo", 8'h01, d);
    wr(ADDR_CTRL[0], 8'h00);
    pulse(2'h2, 1'b0); rd(ADDR_CNT_LO[1], d); chk("cnt1_lo", 8'h01, d);
    wr(ADDR_CTRL[1], 8'h40);
    pulse(2'h2, 1'b0); rd(ADDR_CNT_LO[1], d); chk("cnt1_lo", 8'h02, d);
    wr(ADDR_STATUS, 8'h00); wr(ADDR_CNT_LO[1], 8'hFF); wr(ADDR_CNT_HI[1], 8'hFF);
    pulse(2'h2, 1'b0); rd(ADDR_STATUS, d); chk("status", 8'h80, d);
    chk("irq", 8'h00, {7'h00, irq});
    wr(ADDR_CTRL[1], 8'h60); rd(ADDR_STATUS, d);
    chk("irq", 8'h01, {7'h00, irq});
    $display("test block one done");
    wr(ADDR_STATUS, 8'h00); wr(ADDR_CTRL[0], 8'h40); wr(ADDR_MODE[0], 8'h88);
    wr(ADDR_CMP_LO[0], 8'h05); wr(ADDR_CMP_HI[0], 8'h00);
    wr(ADDR_CNT_LO[0], 8'h04); wr(ADDR_CNT_HI[0], 8'h00);
    pulse(2'h1, 1'b0); rd(ADDR_STATUS, d); chk("status", 8'h01, d);
    chk("irq", 8'h01, {7'h00, irq});
    wr(ADDR_STATUS, 8'h01); rd(ADDR_STATUS, d); chk("status", 8'h01, d);
    wr(ADDR_STATUS, 8'h00); rd(ADDR_STATUS, d); chk("status", 8'h00, d);
    $display("test match flag done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_MODE[0], d); chk("mode0", 8'h00, d);
    rd(ADDR_CTRL[1], d); chk("ctrl1", 8'h00, d);
    chk("irq", 8'h00, {7'h00, irq});
    $display("test second reset done");
    conclude();
  end
endmodule : tb
`default_nettype wire
